/* design/cjtap_consts.svh */
/*
 Constants for the test access port of the CAM: instruction codes,
 boundary chain length, reset edge count and idle pin levels.
 Assumes inclusion by the package, the top module and the bench only.
*/
`ifndef CJTAP_CONSTS_SVH
`define CJTAP_CONSTS_SVH
`define CJTAP_IR_W 4
`define CJTAP_BSR_LEN 63
`define CJTAP_IR_BYPASS 4'hF
`define CJTAP_IR_SAMPLE 4'h2
`define CJTAP_IR_EXTEST 4'h0
`define CJTAP_IR_HIGHZ 4'h9
`define CJTAP_IR_CLAMP 4'hC
`define CJTAP_IR_CAPT 4'h1
`define CJTAP_TLR_EDGES 5
`define CJTAP_PIN_IDLE 4'h7
`endif

/* design/cjtap_pkg.sv */
/*
 Types for the test access port: controller states and the pin groups
 of the boundary chain.
 Assumes cjtap_consts.svh is on the include path.
*/
`include "cjtap_consts.svh"
package cjtap_pkg;
  // State codes, not Gray: a step along the shift-DR or shift-IR path can flip two bits
  typedef enum logic [3:0] {
    CJT_TLR = 4'hF, CJT_RTI = 4'hC, CJT_SDS = 4'h7, CJT_CDR = 4'h6,
    CJT_SDR = 4'h2, CJT_E1D = 4'h1, CJT_PDR = 4'h3, CJT_E2D = 4'h0,
    CJT_UDR = 4'h5, CJT_SIS = 4'h4, CJT_CIR = 4'hE, CJT_SIR = 4'hA,
    CJT_E1I = 4'h9, CJT_PIR = 4'hB, CJT_E2I = 4'h8, CJT_UIR = 4'hD
  } cjtap_state_t;

  // Device pins in boundary order, first-out at the top
  typedef struct packed {
    logic out_enable_n;
    logic match_strobe_pin;
    logic path_circuit_select_pin;
    logic match_control_pin;
    logic [15:0] match_result_hi;
    logic hit_status_pin;
    logic full_flag_pin;
    logic [15:0] match_result_lo;
    logic [15:0] control_data_bus;
    logic iface_clk;
    logic [2:0] control_address_bus;
    logic write_enable;
    logic select;
    logic sys_reset;
    logic irq_n;
    logic transfer_acknowledge_out;
  } cjtap_pins_t;

  // Sampled TAP pins
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } cjtap_tap_in_t;
endpackage

/* design/cjtap_top.sv */
/*
 Test access port and 63-bit boundary chain of the CAM, running on
 sys_clk which oversamples the test clock pins.
 Assumes tap pins arrive already pulled (undriven reads 1) as seen at
 the pad, and that the core pins are presented as cjtap_pins_t.
*/
`timescale 1ns/1ps
`include "cjtap_consts.svh"
module cjtap_top (
  // System
  input wire logic sys_clk,
  input wire logic nrst,
  // Test pins, asynchronous to sys_clk
  input wire cjtap_pkg::cjtap_tap_in_t tap_in,
  output logic tdo_out,
  output logic tdo_oe_n,
  // Core pins and boundary drive
  input wire cjtap_pkg::cjtap_pins_t pins_in,
  output cjtap_pkg::cjtap_pins_t pins_drv_ff_o,
  output logic pins_test_ff_o,
  output logic pins_highz_ff_o
);
  import cjtap_pkg::*;

  // Two-stage synchronisers; first stage read only by second
  cjtap_tap_in_t sync1_ff, sync2_ff;
  logic tck_d_ff;
  logic trst_s1_ff, trst_s2_ff;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      // Idle pin levels (clock low) so no false test clock edge follows reset
      sync1_ff <= `CJTAP_PIN_IDLE;
      sync2_ff <= `CJTAP_PIN_IDLE;
      tck_d_ff <= 1'b0;
    end else begin
      sync1_ff <= tap_in;
      sync2_ff <= sync1_ff;
      tck_d_ff <= sync2_ff.tck;
    end
  end
  // Test reset held asynchronously into the controller
  always_ff @(posedge sys_clk or negedge tap_in.trst_n) begin
    if (!tap_in.trst_n) begin
      trst_s1_ff <= 1'b0;
      trst_s2_ff <= 1'b0;
    end else begin
      trst_s1_ff <= 1'b1;
      trst_s2_ff <= trst_s1_ff;
    end
  end

  logic tck_rise, tck_fall, tap_rst;
  assign tck_rise = sync2_ff.tck & ~tck_d_ff;
  assign tck_fall = ~sync2_ff.tck & tck_d_ff;
  assign tap_rst = ~trst_s2_ff | ~nrst;

  function automatic cjtap_state_t next_state(input cjtap_state_t s, input logic m);
    case (s)
      CJT_TLR: next_state = m ? CJT_TLR : CJT_RTI;
      CJT_RTI: next_state = m ? CJT_SDS : CJT_RTI;
      CJT_SDS: next_state = m ? CJT_SIS : CJT_CDR;
      CJT_CDR: next_state = m ? CJT_E1D : CJT_SDR;
      CJT_SDR: next_state = m ? CJT_E1D : CJT_SDR;
      CJT_E1D: next_state = m ? CJT_UDR : CJT_PDR;
      CJT_PDR: next_state = m ? CJT_E2D : CJT_PDR;
      CJT_E2D: next_state = m ? CJT_UDR : CJT_SDR;
      CJT_UDR: next_state = m ? CJT_SDS : CJT_RTI;
      CJT_SIS: next_state = m ? CJT_TLR : CJT_CIR;
      CJT_CIR: next_state = m ? CJT_E1I : CJT_SIR;
      CJT_SIR: next_state = m ? CJT_E1I : CJT_SIR;
      CJT_E1I: next_state = m ? CJT_UIR : CJT_PIR;
      CJT_PIR: next_state = m ? CJT_E2I : CJT_PIR;
      CJT_E2I: next_state = m ? CJT_UIR : CJT_SIR;
      CJT_UIR: next_state = m ? CJT_SDS : CJT_RTI;
      default: next_state = CJT_TLR;
    endcase
  endfunction

  // Instruction selects the boundary chain or the bypass bit
  function automatic logic uses_bsr(input logic [`CJTAP_IR_W-1:0] ir);
    uses_bsr = (ir == `CJTAP_IR_SAMPLE) || (ir == `CJTAP_IR_EXTEST);
  endfunction

  cjtap_state_t st_ff, nxt_st;
  logic [`CJTAP_IR_W-1:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
  logic bypass_ff, nxt_bypass;
  logic [`CJTAP_BSR_LEN-1:0] bsr_ff, nxt_bsr, upd_ff, nxt_upd;
  logic tdo_ff, nxt_tdo, oe_n_ff, nxt_oe_n;
  logic test_ff, nxt_test, hz_ff, nxt_hz;

  // Next-state for controller and serial registers
  always_comb begin
    nxt_st = st_ff;
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    nxt_bypass = bypass_ff;
    nxt_bsr = bsr_ff;
    nxt_upd = upd_ff;
    nxt_tdo = tdo_ff;
    nxt_oe_n = oe_n_ff;
    nxt_test = test_ff;
    nxt_hz = hz_ff;
    if (tck_rise) begin
      nxt_st = next_state(st_ff, sync2_ff.tms);
      case (st_ff)
        CJT_TLR: nxt_ir = `CJTAP_IR_BYPASS;
        CJT_CIR: nxt_ir_sh = `CJTAP_IR_CAPT;
        CJT_SIR: nxt_ir_sh = {sync2_ff.tdi, ir_sh_ff[`CJTAP_IR_W-1:1]};
        CJT_UIR: nxt_ir = ir_sh_ff;
        CJT_CDR: begin
          nxt_bypass = 1'b0;
          if (uses_bsr(ir_ff)) nxt_bsr = pins_in;
        end
        CJT_SDR: begin
          if (uses_bsr(ir_ff)) begin
            // Shift toward the msb so the output enable bit leaves first
            nxt_bsr = {bsr_ff[`CJTAP_BSR_LEN-2:0], sync2_ff.tdi};
          end else begin
            nxt_bypass = sync2_ff.tdi;
          end
        end
        CJT_UDR: if (uses_bsr(ir_ff)) nxt_upd = bsr_ff;
        default: ;
      endcase
    end
    if (tck_fall) begin
      // Data out, its enable and the drive flags move only on the falling test clock edge or on tap reset
      // Reset state forces bypass at once, so pin drive drops without a rise
      if (st_ff == CJT_TLR) nxt_ir = `CJTAP_IR_BYPASS;
      nxt_oe_n = ~((st_ff == CJT_SIR) || (st_ff == CJT_SDR));
      if (st_ff == CJT_SIR) nxt_tdo = ir_sh_ff[0];
      else nxt_tdo = uses_bsr(ir_ff) ? bsr_ff[`CJTAP_BSR_LEN-1] : bypass_ff;
      nxt_test = (nxt_ir == `CJTAP_IR_EXTEST) || (nxt_ir == `CJTAP_IR_CLAMP);
      nxt_hz = (nxt_ir == `CJTAP_IR_HIGHZ);
    end
  end

  // Test-side state; reset only by tap reset, system logic untouched
  always_ff @(posedge sys_clk) begin
    if (tap_rst) begin
      st_ff <= CJT_TLR;
      ir_sh_ff <= `CJTAP_IR_CAPT;
      ir_ff <= `CJTAP_IR_BYPASS;
      bypass_ff <= 1'b0;
      bsr_ff <= '0;
      upd_ff <= '0;
      tdo_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      test_ff <= 1'b0;
      hz_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
      bypass_ff <= nxt_bypass;
      bsr_ff <= nxt_bsr;
      upd_ff <= nxt_upd;
      tdo_ff <= nxt_tdo;
      oe_n_ff <= nxt_oe_n;
      test_ff <= nxt_test;
      hz_ff <= nxt_hz;
    end
  end

  assign tdo_out = tdo_ff;
  assign tdo_oe_n = oe_n_ff;
  assign pins_drv_ff_o = upd_ff;
  assign pins_test_ff_o = test_ff;
  assign pins_highz_ff_o = hz_ff;

  // Helper: count consecutive high-mode rising edges
  // Saturates at the reset count so it never wraps back below it
  logic [2:0] hi_cnt_ff, nxt_hi_cnt;
  always_comb begin
    nxt_hi_cnt = hi_cnt_ff;
    if (tck_rise && !sync2_ff.tms) nxt_hi_cnt = 3'h0;
    else if (tck_rise && (hi_cnt_ff != 3'(`CJTAP_TLR_EDGES))) nxt_hi_cnt = hi_cnt_ff + 3'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (tap_rst) hi_cnt_ff <= 3'h0;
    else hi_cnt_ff <= nxt_hi_cnt;
  end

  sequence rise_s;
    tck_rise;
  endsequence

  five_high_a: assert property (@(posedge sys_clk) disable iff (tap_rst)
    (hi_cnt_ff == 3'(`CJTAP_TLR_EDGES)) |-> st_ff == CJT_TLR)
    else $error("five high mode edges did not reach reset");
  trst_reset_a: assert property (@(posedge sys_clk)
    !trst_s2_ff |=> st_ff == CJT_TLR)
    else $error("test reset did not force reset state");
  tdo_shift_a: assert property (@(posedge sys_clk) disable iff (tap_rst)
    tck_fall && st_ff != CJT_SIR && st_ff != CJT_SDR |=> tdo_oe_n)
    else $error("data out driven outside shift states");
  tdo_drive_a: assert property (@(posedge sys_clk) disable iff (tap_rst)
    tck_fall && (st_ff == CJT_SIR || st_ff == CJT_SDR) |=> !tdo_oe_n)
    else $error("data out not driven in a shift state");
  tdo_fall_a: assert property (@(posedge sys_clk) disable iff (tap_rst)
    $changed(tdo_out) |-> $past(tck_fall))
    else $error("data out moved without a falling edge");
  state_rise_a: assert property (@(posedge sys_clk) disable iff (tap_rst)
    $changed(st_ff) |-> $past(tck_rise))
    else $error("state moved without a rising edge");
  tlr_ir_a: assert property (@(posedge sys_clk) disable iff (tap_rst)
    rise_s and st_ff == CJT_TLR |=> ir_ff == `CJTAP_IR_BYPASS)
    else $error("reset state did not load bypass");
  capture_a: assert property (@(posedge sys_clk) disable iff (tap_rst)
    rise_s and st_ff == CJT_CDR && uses_bsr(ir_ff) |=> bsr_ff == $past(pins_in))
    else $error("capture did not load pin values");
  shift_tdi_a: assert property (@(posedge sys_clk) disable iff (tap_rst)
    rise_s and st_ff == CJT_SDR && uses_bsr(ir_ff)
      |=> bsr_ff[0] == $past(sync2_ff.tdi))
    else $error("data in not shifted into chain");
endmodule

/* dv/cjtap_host.sv */
/*
 Test controller model driving the TAP pins of cjtap_top.
 Assumes the bench calls its tasks from idle; tck rests low between frames.
*/
`timescale 1ns/1ps
module cjtap_host (
  // Clock
  input wire logic sys_clk,
  // Test pins
  output cjtap_pkg::cjtap_tap_in_t tap,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  import cjtap_pkg::*;
  // Idle: clock low, mode and data pulled high
  initial tap = 4'h7;
  // One test clock; data out read mid-high, where it cannot be moving
  task automatic tbit(input logic ms, input logic di, output logic td, output logic oe);
    tap.tms <= ms;
    tap.tdi <= di;
    repeat (4) @(posedge sys_clk);
    tap.tck <= 1'b1;
    repeat (2) @(posedge sys_clk);
    td = tdo;
    oe = tdo_oe_n;
    repeat (2) @(posedge sys_clk);
    tap.tck <= 1'b0;
  endtask
  // Mode sequence, first bit at lsb; data in left high as if undriven
  task automatic walk(input logic [7:0] ms, input int n);
    logic d;
    logic o;
    for (int i = 0; i < n; i++) tbit(ms[i], 1'b1, d, o);
  endtask
  // Full scan from idle back to idle; oe collects any high enable seen
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout, output logic oe);
    logic d;
    logic o;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    oe = 1'b0;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tbit(i == n - 1, din[i], d, o);
      dout[i] = d;
      oe = oe | o;
    end
    walk(8'h01, 2);
    // Let the last falling edge reach the registered outputs
    repeat (6) @(posedge sys_clk);
  endtask
  // Test reset pin, changed just after a clock edge
  task automatic set_trst(input logic v);
    tap.trst_n <= v;
  endtask
endmodule

/* dv/tb_cjtap_top.sv */
/*
 Self-checking bench for cjtap_top driven through the controller model.
 Assumes cjtap_pkg and cjtap_host are compiled before it.
*/
`timescale 1ns/1ps
`include "cjtap_consts.svh"
module tb_cjtap_top;
  import cjtap_pkg::*;
  // Stimulus and observed pins
  logic sys_clk;
  logic nrst;
  cjtap_tap_in_t tap_in;
  logic tdo_out;
  logic tdo_oe_n;
  cjtap_pins_t pins_in;
  cjtap_pins_t pins_drv;
  logic pins_test;
  logic pins_highz;
  int num_errors;
  int checks;
  logic [63:0] din = 64'h9E37_79B9_7F4A_7C15;
  logic [63:0] dout;
  logic [63:0] exp_o;
  logic oe;
  // Rows: code, drive flags, chain length; 5 is unlisted and acts as bypass
  typedef struct {logic [3:0] code; logic test; logic hz; int len;} cjtap_row_t;
  cjtap_row_t rows [6] = '{
    '{`CJTAP_IR_SAMPLE, 1'b0, 1'b0, 63}, '{`CJTAP_IR_EXTEST, 1'b1, 1'b0, 63},
    '{`CJTAP_IR_HIGHZ, 1'b0, 1'b1, 1}, '{`CJTAP_IR_CLAMP, 1'b1, 1'b0, 1},
    '{`CJTAP_IR_BYPASS, 1'b0, 1'b0, 1}, '{4'h5, 1'b0, 1'b0, 1}};
  cjtap_top dut (.sys_clk(sys_clk), .nrst(nrst), .tap_in(tap_in), .tdo_out(tdo_out),
    .tdo_oe_n(tdo_oe_n), .pins_in(pins_in), .pins_drv_ff_o(pins_drv),
    .pins_test_ff_o(pins_test), .pins_highz_ff_o(pins_highz));
  cjtap_host host (.sys_clk(sys_clk), .tap(tap_in), .tdo(tdo_out), .tdo_oe_n(tdo_oe_n));
  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    pins_in = 63'h2A5A_1234_F0F0_C3C3;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check("oe_rst", tdo_oe_n, 1'b1);
    check("flags_rst", {pins_test, pins_highz}, 2'b00);
    host.walk(8'h00, 1);
    foreach (rows[r]) begin
      host.scan(1'b1, 4, {60'h0, rows[r].code}, dout, oe);
      check("ir_capture", dout[3:0], 4'h1);
      check("ir_oe", oe, 1'b0);
      check("ir_flags", {pins_test, pins_highz}, {rows[r].test, rows[r].hz});
      host.scan(1'b0, 64, din, dout, oe);
      exp_o = {din[62:0], 1'b0};
      if (rows[r].len == 63) begin
        for (int i = 0; i < 63; i++) exp_o[i] = pins_in[62 - i];
        exp_o[63] = din[0];
      end
      check("dr_out", dout, exp_o);
      check("dr_oe", oe, 1'b0);
      for (int i = 0; i < 63; i++) exp_o[i] = din[63 - i];
      if (rows[r].len == 63) check("preload", pins_drv, exp_o[62:0]);
    end
    // Four high mode edges from shift-DR stop short of reset; the fifth lands
    host.scan(1'b1, 4, {60'h0, `CJTAP_IR_EXTEST}, dout, oe);
    host.walk(8'h01, 3);
    host.walk(8'hFF, 4);
    check("four_edges", pins_test, 1'b1);
    host.walk(8'hFF, 1);
    repeat (6) @(posedge sys_clk);
    check("five_edges", pins_test, 1'b0);
    // Test reset with no test clock running
    host.walk(8'h00, 1);
    host.scan(1'b1, 4, {60'h0, `CJTAP_IR_EXTEST}, dout, oe);
    host.set_trst(1'b0);
    repeat (3) @(posedge sys_clk);
    check("trst_flags", pins_test, 1'b0);
    check("trst_oe", tdo_oe_n, 1'b1);
    host.set_trst(1'b1);
    repeat (4) @(posedge sys_clk);
    wrap_up();
  end
endmodule
